//--- verilog/pmcb_defines.svh
/*
  constants for the power manager configuration bank: offsets, fields,
  reset values and timing counts. assumes a 20 MHz mclk.
*/
`ifndef PMCB_DEFINES_SVH
`define PMCB_DEFINES_SVH

// printed offsets are not multiples of four: index, byte address = 4*index
`define PMCB_IDX_AUTOSTART 12'h10c
`define PMCB_IDX_MERGE 12'h10d
`define PMCB_IDX_SHUTDOWN 12'h10e
`define PMCB_IDX_IFRESET 12'h10f
`define PMCB_IDX_RESETDUR 12'h120
`define PMCB_IDX_STATUS 12'h121

`define PMCB_RST_BYTE 8'h00
`define PMCB_RST_RESETDUR 8'h00

// regulator_autostart_config fields
`define PMCB_BIT_REG3_FORCE 2
`define PMCB_BIT_REG2_FORCE 1
`define PMCB_BIT_REG1_FORCE 0
// mem_io_merge_mode_config fields
`define PMCB_BIT_MEM_IO_MERGE 7
`define PMCB_BIT_CORE_A_FULL 6
`define PMCB_BIT_CORE_B_FULL 5
`define PMCB_BIT_PROC_FULL 4
`define PMCB_BIT_CORE_DUAL 3
`define PMCB_BIT_SENSE_ROUTE 2
`define PMCB_BIT_VIBE_SEL 1
`define PMCB_BIT_PWM_CLK 0
// shutdown_key_config fields
`define PMCB_BIT_CL_SHUTDOWN 7
`define PMCB_BIT_FAULT_STYLE 6
`define PMCB_BIT_HOST_STYLE 5
`define PMCB_BIT_KEY_STYLE 4
`define PMCB_BIT_DUAL_INPUT 3
`define PMCB_BIT_LONG_PRESS 2
`define PMCB_MSB_KEY_MODE 1
`define PMCB_LSB_KEY_MODE 0
// interface_reset_config fields
`define PMCB_BIT_IF_RESET 7
`define PMCB_BIT_SCL_TIMEOUT 6
// reset_duration_config field
`define PMCB_MSB_RESET_DUR 1
`define PMCB_LSB_RESET_DUR 0

// timing
`define PMCB_CLK_HZ 20000000
`define PMCB_CL_LIMIT_MS 200
`define PMCB_SCL_TIMEOUT_MS 19
`define PMCB_RESET_DUR0_MS 20
`define PMCB_RESET_DUR1_MS 100
`define PMCB_RESET_DUR2_MS 500
`define PMCB_RESET_DUR3_MS 1000
`define PMCB_CYCLES_PER_MS (`PMCB_CLK_HZ / 1000)
`define PMCB_CL_LIMIT_CYC (`PMCB_CL_LIMIT_MS * `PMCB_CYCLES_PER_MS)
`define PMCB_SCL_TIMEOUT_CYC (`PMCB_SCL_TIMEOUT_MS * `PMCB_CYCLES_PER_MS)
`define PMCB_RESET_DUR0_CYC (`PMCB_RESET_DUR0_MS * `PMCB_CYCLES_PER_MS)
`define PMCB_RESET_DUR1_CYC (`PMCB_RESET_DUR1_MS * `PMCB_CYCLES_PER_MS)
`define PMCB_RESET_DUR2_CYC (`PMCB_RESET_DUR2_MS * `PMCB_CYCLES_PER_MS)
`define PMCB_RESET_DUR3_CYC (`PMCB_RESET_DUR3_MS * `PMCB_CYCLES_PER_MS)

`endif

//--- verilog/pmcb_pkg.sv
/*
  types for the power manager configuration bank.
  assumes pmcb_defines.svh holds the numbers.
*/
package pmcb_pkg;
  typedef enum logic [1:0] {
    key_port_mode,
    key_lock_sw_off,
    key_lock_auto_off,
    key_power_key
  } pmcb_key_mode_type;

  typedef enum logic [1:0] {
    st_on,
    st_por,
    st_reset_wait
  } pmcb_power_state_type;
endpackage

//--- verilog/pmcb_config_bank.sv
/*
  power manager configuration bank with apb slave and the small amount of
  control logic the bank steers (shutdown decode, limit timers, timeouts).
  assumes a 20 MHz mclk, synchronous reset, and pins async to mclk.
*/
// Local design decision: the APB register port.
// Operation
// [R1] regulator powerup force bits 2..0
// [R2] memory/io merge masks io buck control
// [R3] full current bits for three bucks
// [R4] core dual phase masks core b control
// [R5] sense route selects feedback or switch sense
// [R6] host avoids feedback pattern x1x with route
// [R7] regulator eight mode selects vibration driver
// [R8] pwm clock bit selects 2 or 1 MHz
// [R9] limit shutdown after 200 ms continuous limit
// [R10] fault shutdown fast or normal
// [R11] host shutdown fast or normal
// [R12] key shutdown normal or instant por
// [R13] after por wait reset duration first
// [R14] dual gpi shutdown only when enabled
// [R15] long press shutdown only when enabled
// [R16] two bit power key mode field
// [R17] shutdown pin resets control interfaces
// [R18] serial clock stall over 19 ms resets
// [R19] reset duration 20/100/500/1000 ms
// [R20] fields hold last written value
`timescale 1ns/1ps
`include "pmcb_defines.svh"

module pmcb_config_bank #(
  parameter int CL_LIMIT_CYC = `PMCB_CL_LIMIT_CYC,
  parameter int SCL_TIMEOUT_CYC = `PMCB_SCL_TIMEOUT_CYC,
  parameter int RESET_DUR0_CYC = `PMCB_RESET_DUR0_CYC,
  parameter int RESET_DUR1_CYC = `PMCB_RESET_DUR1_CYC,
  parameter int RESET_DUR2_CYC = `PMCB_RESET_DUR2_CYC,
  parameter int RESET_DUR3_CYC = `PMCB_RESET_DUR3_CYC,
  parameter int NUM_LIMIT = 5
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // asynchronous pins and events
  input wire logic shutdown_request_pin_n,
  input wire logic power_key_long_press,
  input wire logic gpi14_in,
  input wire logic gpi15_in,
  input wire logic serial_clock_in,
  input wire logic [NUM_LIMIT-1:0] current_limit_active,
  input wire logic fault_shutdown_req,
  input wire logic host_shutdown_bit,
  // configuration outputs
  output logic reg3_powerup_force,
  output logic reg2_powerup_force,
  output logic reg1_powerup_force,
  output logic core_a_full_current,
  output logic core_b_full_current,
  output logic proc_buck_full_current,
  output logic io_buck_ctrl_enable,
  output logic core_b_ctrl_enable,
  output logic sense_on_feedback_port_two,
  output logic sense_on_core_switch,
  output logic vibe_driver_select,
  output logic pwm_clk_1mhz,
  output logic [1:0] power_key_mode,
  // shutdown and reset actions
  output logic [NUM_LIMIT-1:0] limit_regulator_off,
  output logic shutdown_start,
  output logic shutdown_fast,
  output logic power_on_reset,
  output logic powerup_allowed,
  output logic ctrl_if_reset,
  output logic serial_if_reset
);

  logic [7:0] autostart_reg;
  logic [7:0] merge_reg;
  logic [7:0] shutdown_reg;
  logic [7:0] ifreset_reg;
  logic [7:0] resetdur_reg;
  logic [11:0] index;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [7:0] rdata_next;

  // apb: zero wait states, unmapped or misaligned answers pslverr
  assign index = paddr[13:2];
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[31:14] == 18'h0_0000) &&
    (index == `PMCB_IDX_AUTOSTART || index == `PMCB_IDX_MERGE ||
     index == `PMCB_IDX_SHUTDOWN || index == `PMCB_IDX_IFRESET ||
     index == `PMCB_IDX_RESETDUR || index == `PMCB_IDX_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en = psel && penable && pwrite && addr_ok && pstrb[0];
  assign rd_en = psel && !penable && !pwrite;

  // see [R20]
  always_ff @(posedge mclk) begin
    if (reset) begin
      autostart_reg <= `PMCB_RST_BYTE;
      merge_reg <= `PMCB_RST_BYTE;
      shutdown_reg <= `PMCB_RST_BYTE;
      ifreset_reg <= `PMCB_RST_BYTE;
      resetdur_reg <= `PMCB_RST_RESETDUR;
    end else if (wr_en) begin
      case (index)
        `PMCB_IDX_AUTOSTART: autostart_reg <= pwdata[7:0];
        `PMCB_IDX_MERGE: merge_reg <= pwdata[7:0];
        `PMCB_IDX_SHUTDOWN: shutdown_reg <= pwdata[7:0];
        `PMCB_IDX_IFRESET: ifreset_reg <= {pwdata[7:6], 6'h00};
        `PMCB_IDX_RESETDUR: resetdur_reg <= {6'h00, pwdata[1:0]};
        default: begin
        end
      endcase
    end
  end

  // pin synchronisers, two flops each
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic [NUM_LIMIT-1:0] lim1_reg;
  logic [NUM_LIMIT-1:0] lim2_reg;
  // reset to each pin's idle level so no edge detector fires after reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      sync1_reg <= 5'h10;
      sync2_reg <= 5'h10;
    end else begin
      sync1_reg <= {shutdown_request_pin_n, power_key_long_press,
                    gpi14_in, gpi15_in, serial_clock_in};
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      lim1_reg <= '0;
      lim2_reg <= '0;
    end else begin
      lim1_reg <= current_limit_active;
      lim2_reg <= lim1_reg;
    end
  end
  logic shdn_pin_act;
  logic long_press_s;
  logic gpi_both_s;
  logic scl_s;
  assign shdn_pin_act = !sync2_reg[4];
  assign long_press_s = sync2_reg[3];
  assign gpi_both_s = sync2_reg[2] && sync2_reg[1];
  assign scl_s = sync2_reg[0];

  // plain configuration outputs
  assign reg3_powerup_force = autostart_reg[`PMCB_BIT_REG3_FORCE]; // see [R1]
  assign reg2_powerup_force = autostart_reg[`PMCB_BIT_REG2_FORCE]; // see [R1]
  assign reg1_powerup_force = autostart_reg[`PMCB_BIT_REG1_FORCE]; // see [R1]
  assign core_a_full_current = merge_reg[`PMCB_BIT_CORE_A_FULL]; // see [R3]
  assign core_b_full_current = merge_reg[`PMCB_BIT_CORE_B_FULL]; // see [R3]
  assign proc_buck_full_current = merge_reg[`PMCB_BIT_PROC_FULL]; // see [R3]
  assign io_buck_ctrl_enable = !merge_reg[`PMCB_BIT_MEM_IO_MERGE]; // see [R2]
  assign core_b_ctrl_enable = !merge_reg[`PMCB_BIT_CORE_DUAL]; // see [R4]
  // route only matters when the core bucks are merged; see [R5]
  assign sense_on_feedback_port_two = merge_reg[`PMCB_BIT_CORE_DUAL] &&
    !merge_reg[`PMCB_BIT_SENSE_ROUTE];
  assign sense_on_core_switch = merge_reg[`PMCB_BIT_CORE_DUAL] &&
    merge_reg[`PMCB_BIT_SENSE_ROUTE];
  assign vibe_driver_select = merge_reg[`PMCB_BIT_VIBE_SEL]; // see [R7]
  assign pwm_clk_1mhz = merge_reg[`PMCB_BIT_PWM_CLK]; // see [R8]
  assign power_key_mode =
    shutdown_reg[`PMCB_MSB_KEY_MODE:`PMCB_LSB_KEY_MODE]; // see [R16]

  // current limit timers, one per limited regulator
  genvar g;
  generate
    for (g = 0; g < NUM_LIMIT; g = g + 1) begin : g_limit
      logic [31:0] cnt_reg;
      logic off_reg;
      always_ff @(posedge mclk) begin
        if (reset) begin
          cnt_reg <= 32'h0000_0000;
          off_reg <= 1'b0;
        end else if (!shutdown_reg[`PMCB_BIT_CL_SHUTDOWN]) begin
          cnt_reg <= 32'h0000_0000;
          off_reg <= 1'b0;
        end else if (!lim2_reg[g]) begin
          cnt_reg <= 32'h0000_0000;
        end else if (cnt_reg < CL_LIMIT_CYC) begin
          cnt_reg <= cnt_reg + 32'h0000_0001;
        end else begin
          off_reg <= 1'b1; // see [R9]
        end
      end
      assign limit_regulator_off[g] = off_reg;
    end
  endgenerate

  // shutdown decode
  logic key_trigger;
  logic host_trigger;
  logic shdn_pin_d_reg;
  logic host_bit_d_reg;
  logic key_d_reg;
  // see [R14] see [R15]
  assign key_trigger =
    (shutdown_reg[`PMCB_BIT_DUAL_INPUT] && gpi_both_s) ||
    (shutdown_reg[`PMCB_BIT_LONG_PRESS] && long_press_s);
  assign host_trigger = shdn_pin_act || host_shutdown_bit;

  // host bit and fault request share mclk, so they need no synchroniser
  always_ff @(posedge mclk) begin
    if (reset) begin
      shdn_pin_d_reg <= 1'b0;
    end else begin
      shdn_pin_d_reg <= host_trigger;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      host_bit_d_reg <= 1'b0;
    end else begin
      host_bit_d_reg <= fault_shutdown_req;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      key_d_reg <= 1'b0;
    end else begin
      key_d_reg <= key_trigger;
    end
  end

  logic host_rise;
  logic fault_rise;
  logic key_rise;
  assign host_rise = host_trigger && !shdn_pin_d_reg;
  assign fault_rise = fault_shutdown_req && !host_bit_d_reg;
  assign key_rise = key_trigger && !key_d_reg;

  pmcb_pkg::pmcb_power_state_type state_reg;
  logic [31:0] wait_reg;
  logic [31:0] dur_cyc;
  always_comb begin
    unique case (resetdur_reg[`PMCB_MSB_RESET_DUR:`PMCB_LSB_RESET_DUR])
      2'b00: dur_cyc = RESET_DUR0_CYC; // see [R19]
      2'b01: dur_cyc = RESET_DUR1_CYC;
      2'b10: dur_cyc = RESET_DUR2_CYC;
      2'b11: dur_cyc = RESET_DUR3_CYC;
    endcase
  end

  logic por_entry;
  assign por_entry = key_rise && shutdown_reg[`PMCB_BIT_KEY_STYLE];

  // sequence start pulse, registered; nothing starts during por or wait
  always_ff @(posedge mclk) begin
    if (reset) begin
      shutdown_start <= 1'b0;
    end else begin
      shutdown_start <= (state_reg == pmcb_pkg::st_on) &&
        (fault_rise || host_rise || (key_rise && !por_entry));
    end
  end

  // style of the latest trigger; fault outranks host, host outranks key
  always_ff @(posedge mclk) begin
    if (reset) begin
      shutdown_fast <= 1'b0;
    end else if (fault_rise) begin
      shutdown_fast <= shutdown_reg[`PMCB_BIT_FAULT_STYLE]; // see [R10]
    end else if (host_rise) begin
      shutdown_fast <= shutdown_reg[`PMCB_BIT_HOST_STYLE]; // see [R11]
    end else if (key_rise) begin
      shutdown_fast <= 1'b0; // see [R12]
    end
  end

  // por holds one cycle then the reset duration must expire
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= pmcb_pkg::st_on;
      wait_reg <= 32'h0000_0000;
    end else begin
      unique case (state_reg)
        pmcb_pkg::st_on: begin
          if (por_entry) begin
            state_reg <= pmcb_pkg::st_por; // see [R12]
          end
        end
        pmcb_pkg::st_por: begin
          state_reg <= pmcb_pkg::st_reset_wait;
          wait_reg <= 32'h0000_0000;
        end
        pmcb_pkg::st_reset_wait: begin
          if (wait_reg >= dur_cyc - 32'h0000_0001) begin
            state_reg <= pmcb_pkg::st_on; // see [R13]
          end else begin
            wait_reg <= wait_reg + 32'h0000_0001;
          end
        end
      endcase
    end
  end
  assign power_on_reset = (state_reg == pmcb_pkg::st_por);
  assign powerup_allowed = (state_reg == pmcb_pkg::st_on);

  // interface resets
  assign ctrl_if_reset = ifreset_reg[`PMCB_BIT_IF_RESET] &&
    shdn_pin_act; // see [R17]

  logic scl_d_reg;
  logic [31:0] stall_reg;
  logic scl_rst_reg;
  // idle level of the serial clock, matching the synchroniser reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      scl_d_reg <= 1'b0;
    end else begin
      scl_d_reg <= scl_s;
    end
  end

  // a clock stuck at either level counts as a stall
  always_ff @(posedge mclk) begin
    if (reset) begin
      stall_reg <= 32'h0000_0000;
      scl_rst_reg <= 1'b0;
    end else begin
      scl_rst_reg <= 1'b0;
      if (!ifreset_reg[`PMCB_BIT_SCL_TIMEOUT] || scl_s != scl_d_reg) begin
        stall_reg <= 32'h0000_0000;
      end else if (stall_reg < SCL_TIMEOUT_CYC) begin
        stall_reg <= stall_reg + 32'h0000_0001;
      end else begin
        // one pulse, then restart timing; see [R18]
        scl_rst_reg <= 1'b1;
        stall_reg <= 32'h0000_0000;
      end
    end
  end
  assign serial_if_reset = scl_rst_reg;

  // read mux, registered during setup so prdata is a flop
  always_comb begin
    unique case (index)
      `PMCB_IDX_AUTOSTART: rdata_next = autostart_reg;
      `PMCB_IDX_MERGE: rdata_next = merge_reg;
      `PMCB_IDX_SHUTDOWN: rdata_next = shutdown_reg;
      `PMCB_IDX_IFRESET: rdata_next = ifreset_reg;
      `PMCB_IDX_RESETDUR: rdata_next = resetdur_reg;
      `PMCB_IDX_STATUS:
        rdata_next = {5'h00, powerup_allowed, shdn_pin_act, scl_rst_reg};
      default: rdata_next = 8'h00;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= {24'h00_0000, rdata_next};
    end
  end

endmodule

//--- test/pmcb_properties.sv
/* port assertions for the config bank: write effects, masks, pulses.
   assumes binding to pmcb_config_bank; byte address is four times index. */
`timescale 1ns/1ps
module pmcb_properties (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // pins and outputs
  input wire logic shutdown_request_pin_n,
  input wire logic reg1_powerup_force,
  input wire logic io_buck_ctrl_enable,
  input wire logic core_b_ctrl_enable,
  input wire logic sense_on_feedback_port_two,
  input wire logic sense_on_core_switch,
  input wire logic vibe_driver_select,
  input wire logic pwm_clk_1mhz,
  input wire logic [1:0] power_key_mode,
  input wire logic shutdown_start,
  input wire logic power_on_reset,
  input wire logic powerup_allowed,
  input wire logic ctrl_if_reset
);
  logic wr_en;
  assign wr_en = psel && penable && pwrite && pstrb[0];
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_autostart_write: assert property (
    wr_en && paddr == 32'h0000_0430 |=> reg1_powerup_force == $past(pwdata[0]))
    else $error("force bit not taken from write");
  a_io_merge_mask: assert property (
    wr_en && paddr == 32'h0000_0434
    |=> io_buck_ctrl_enable == !$past(pwdata[7]))
    else $error("io buck control not masked by merge");
  a_core_b_mask: assert property (
    wr_en && paddr == 32'h0000_0434
    |=> core_b_ctrl_enable == !$past(pwdata[3]))
    else $error("core b control not masked by dual phase");
  a_sense_route: assert property (
    sense_on_core_switch || sense_on_feedback_port_two
    |-> !core_b_ctrl_enable &&
      sense_on_core_switch != sense_on_feedback_port_two)
    else $error("sense route outside dual phase or doubled");
  a_pwm_clock: assert property (
    wr_en && paddr == 32'h0000_0434 |=> pwm_clk_1mhz == $past(pwdata[0]))
    else $error("pwm clock select not taken from write");
  a_vibe_hold: assert property (
    !(wr_en && paddr == 32'h0000_0434) |=> $stable(vibe_driver_select))
    else $error("vibration select changed without write");
  a_key_mode: assert property (
    wr_en && paddr == 32'h0000_0438 |=> power_key_mode == $past(pwdata[1:0]))
    else $error("key mode not taken from write");
  a_if_reset_idle: assert property (
    shutdown_request_pin_n [*3] |-> !ctrl_if_reset)
    else $error("interface reset without shutdown pin");
  a_por_single: assert property (
    power_on_reset |=> !power_on_reset && !powerup_allowed)
    else $error("power on reset not one cycle then wait");
  a_start_pulse: assert property (
    shutdown_start |=> !shutdown_start)
    else $error("shutdown start longer than one cycle");
endmodule

bind pmcb_config_bank pmcb_properties pmcb_properties_i (.mclk, .reset, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .shutdown_request_pin_n,
  .reg1_powerup_force, .io_buck_ctrl_enable, .core_b_ctrl_enable,
  .sense_on_feedback_port_two, .sense_on_core_switch, .vibe_driver_select,
  .pwm_clk_1mhz, .power_key_mode, .shutdown_start, .power_on_reset,
  .powerup_allowed, .ctrl_if_reset);

//--- test/pmcb_host.sv
/* apb host model: one transfer at a time, setup then access phase.
   assumes a slave on mclk; every wait for pready is bounded. */
`timescale 1ns/1ps
module pmcb_host (
  // clock
  input wire logic mclk,
  // apb
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [31:0] paddr = 32'h0000_0000,
  output logic [31:0] pwdata = 32'h0000_0000,
  output logic [3:0] pstrb = 4'h0,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  int timeouts = 0;
  logic [31:0] rdata;
  logic rerr;
  logic [3:0] strb = 4'hf;
  // feedback route settings are written through this host like any other field
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= strb;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      timeouts++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines carry junk so stale values are never trusted
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

//--- test/testbench.sv
/* bench for pmcb_config_bank: apb host model, pins driven here.
   assumes shortened timing parameters and one mclk domain. */
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0] pstrb;
  logic shutdown_request_pin_n = 1'b1;
  logic power_key_long_press = 1'b0;
  logic gpi14_in = 1'b0;
  logic gpi15_in = 1'b0;
  logic serial_clock_in = 1'b0;
  logic [4:0] current_limit_active = 5'h00;
  logic fault_shutdown_req = 1'b0;
  logic host_shutdown_bit = 1'b0;
  logic reg3_powerup_force, reg2_powerup_force, reg1_powerup_force;
  logic core_a_full_current, core_b_full_current, proc_buck_full_current;
  logic io_buck_ctrl_enable, core_b_ctrl_enable, vibe_driver_select;
  logic sense_on_feedback_port_two, sense_on_core_switch, pwm_clk_1mhz;
  logic [1:0] power_key_mode;
  logic [4:0] limit_regulator_off;
  logic shutdown_start, shutdown_fast, power_on_reset, powerup_allowed;
  logic ctrl_if_reset, serial_if_reset;
  logic [5:0] ev;
  logic [8:0] mrg;
  logic [2:0] frc;
  int mismatches = 0;
  int checked = 0;
  int waited;
  assign ev = {powerup_allowed, serial_if_reset, ctrl_if_reset,
    limit_regulator_off[0], power_on_reset, shutdown_start};
  assign mrg = {io_buck_ctrl_enable, core_b_ctrl_enable, core_a_full_current,
    core_b_full_current, proc_buck_full_current, sense_on_feedback_port_two,
    sense_on_core_switch, vibe_driver_select, pwm_clk_1mhz};
  assign frc = {reg3_powerup_force, reg2_powerup_force, reg1_powerup_force};
  pmcb_config_bank #(.CL_LIMIT_CYC(20), .SCL_TIMEOUT_CYC(10),
    .RESET_DUR0_CYC(8), .RESET_DUR1_CYC(12), .RESET_DUR2_CYC(16),
    .RESET_DUR3_CYC(20)) pmcb_config_bank_i (.mclk, .reset, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .shutdown_request_pin_n, .power_key_long_press, .gpi14_in, .gpi15_in,
    .serial_clock_in, .current_limit_active, .fault_shutdown_req,
    .host_shutdown_bit, .reg3_powerup_force, .reg2_powerup_force,
    .reg1_powerup_force, .core_a_full_current, .core_b_full_current,
    .proc_buck_full_current, .io_buck_ctrl_enable, .core_b_ctrl_enable,
    .sense_on_feedback_port_two, .sense_on_core_switch, .vibe_driver_select,
    .pwm_clk_1mhz, .power_key_mode, .limit_regulator_off, .shutdown_start,
    .shutdown_fast, .power_on_reset, .powerup_allowed, .ctrl_if_reset,
    .serial_if_reset);
  pmcb_host pmcb_host_i (.mclk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr);
  initial begin
    forever #25 mclk = ~mclk;
  end
  task automatic give_verdict;
    if (mismatches == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // the #1 lets the completing edge's updates land before any compare
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    pmcb_host_i.xfer(w, a, d);
    #1;
    if (pmcb_host_i.timeouts != 0) begin
      mismatches++;
      give_verdict;
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(pmcb_host_i.rdata, exp);
  endtask
  task automatic await(input int b, input int lim);
    waited = 0;
    checked++;
    while (ev[b] !== 1'b1) begin
      @(posedge mclk);
      waited++;
      if (waited > lim) begin
        mismatches++;
        give_verdict;
      end
    end
    #1;
  endtask
  // counts events in mask while the serial clock toggles every cycle
  task automatic quiet(input int n, input logic [5:0] mask);
    int k;
    k = 0;
    repeat (n) begin
      @(posedge mclk) serial_clock_in <= ~serial_clock_in;
      if ((ev & mask) !== 6'h00)
        k++;
    end
    chk(k, 0);
  endtask
  task automatic t_regs;
    bus(1'b1, 32'h0000_0430, 32'h0000_00a5);
    chk(frc, 3'h5);
    rd(32'h0000_0430, 32'h0000_00a5);
    chk(pmcb_host_i.rerr, 1'b0);
    // a write without byte lane zero must leave the register alone
    pmcb_host_i.strb = 4'he;
    bus(1'b1, 32'h0000_0430, 32'h0000_0000);
    pmcb_host_i.strb = 4'hf;
    rd(32'h0000_0430, 32'h0000_00a5);
    bus(1'b1, 32'h0000_0434, 32'h0000_00f6);
    chk(mrg, 9'h0f2);
    rd(32'h0000_0434, 32'h0000_00f6);
    bus(1'b1, 32'h0000_0434, 32'h0000_000d);
    chk(mrg, 9'h105);
    bus(1'b1, 32'h0000_0434, 32'h0000_0008);
    chk(mrg, 9'h108);
    bus(1'b1, 32'h0000_043c, 32'h0000_00ff);
    rd(32'h0000_043c, 32'h0000_00c0);
    bus(1'b1, 32'h0000_043c, 32'h0000_0000);
    rd(32'h0000_0400, 32'h0000_0000);
    chk(pmcb_host_i.rerr, 1'b1);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 32'h0000_0438, m);
      chk(power_key_mode, m[1:0]);
      rd(32'h0000_0438, m);
    end
  endtask
  task automatic t_limit;
    bus(1'b1, 32'h0000_0438, 32'h0000_0080);
    @(posedge mclk) current_limit_active <= 5'h1f;
    repeat (18) @(posedge mclk);
    #1;
    chk(limit_regulator_off, 5'h00);
    await(2, 30);
    chk(limit_regulator_off, 5'h1f);
    @(posedge mclk) current_limit_active <= 5'h00;
    bus(1'b1, 32'h0000_0438, 32'h0000_0000);
    // the off flags clear one edge after the enable bit drops
    @(posedge mclk);
    #1;
    chk(limit_regulator_off, 5'h00);
  endtask
  task automatic t_shut;
    bus(1'b1, 32'h0000_0438, 32'h0000_0020);
    @(posedge mclk) host_shutdown_bit <= 1'b1;
    await(0, 6);
    chk(shutdown_fast, 1'b1);
    @(posedge mclk) fault_shutdown_req <= 1'b1;
    await(0, 6);
    chk(shutdown_fast, 1'b0);
    @(posedge mclk) begin
      gpi14_in <= 1'b1;
      gpi15_in <= 1'b1;
    end
    quiet(10, 6'h03);
    @(posedge mclk) gpi14_in <= 1'b0;
    bus(1'b1, 32'h0000_0438, 32'h0000_0008);
    @(posedge mclk) gpi14_in <= 1'b1;
    await(0, 10);
    @(posedge mclk) power_key_long_press <= 1'b1;
    quiet(10, 6'h03);
    @(posedge mclk) power_key_long_press <= 1'b0;
    bus(1'b1, 32'h0000_0480, 32'h0000_0001);
    bus(1'b1, 32'h0000_0438, 32'h0000_0014);
    @(posedge mclk) power_key_long_press <= 1'b1;
    await(1, 10);
    chk(powerup_allowed, 1'b0);
    await(5, 30);
    chk(waited >= 11 && waited <= 13, 1'b1);
  endtask
  task automatic t_ifs;
    bus(1'b1, 32'h0000_043c, 32'h0000_0080);
    @(posedge mclk) shutdown_request_pin_n <= 1'b0;
    await(3, 5);
    rd(32'h0000_0484, 32'h0000_0006);
    @(posedge mclk) shutdown_request_pin_n <= 1'b1;
    bus(1'b1, 32'h0000_043c, 32'h0000_0040);
    chk(ctrl_if_reset, 1'b0);
    await(4, 20);
    quiet(20, 6'h10);
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    t_regs;
    t_limit;
    t_shut;
    t_ifs;
    give_verdict;
  end
endmodule
